// [rtl/rfr_pkg.sv]
package rfr_pkg;
  localparam int unsigned       REG_COUNT      = 2048;
  localparam logic [13:0]       ADDR_FIRST     = 14'h0001;
  localparam logic [13:0]       ADDR_LAST      = 14'h0800;
  localparam logic [13:0]       ADDR_FILE_CNT  = 14'h0001;
  localparam logic [13:0]       ADDR_RATE_CODE = 14'h0002;
  localparam logic [13:0]       ADDR_PROT      = 14'h2000;
  localparam logic [10:0]       IDX_FILE_CNT   = 11'h000;
  localparam logic [10:0]       IDX_RATE_CODE  = 11'h001;
  localparam logic [12:0]       IDX_FIRST_FILE = 13'h0002;
  localparam logic [12:0]       IDX_END        = 13'h0800;
  localparam logic [1:0]        HDR_LAST_STEP  = 2'h3;
  localparam logic [1:0]        HDR_STEP_RLEN  = 2'h0;
  localparam logic [1:0]        HDR_STEP_NWIN  = 2'h1;
  localparam logic [12:0]       WIN_CMD_SKIP   = 13'h0002;
  localparam int unsigned       PROT_LOCK_BIT  = 0;
  localparam int unsigned       PROT_WP_BIT    = 1;
  localparam logic [15:0]       PROT_MASK      = 16'h0003;
  localparam logic [15:0]       CMD_ALTER_MASK = 16'h003f;
  localparam logic [15:0]       REG_RESET      = 16'h0000;
  localparam logic [1:0]        ROLE_DATA      = 2'h0;
  localparam logic [1:0]        ROLE_CFG       = 2'h1;
  localparam logic [1:0]        ROLE_STAT      = 2'h2;
  localparam logic [1:0]        ROLE_CMD       = 2'h3;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [13:0] addr;
    logic [15:0] wdata;
  } rfr_req_t;

  typedef struct packed {
    logic        valid;
    logic [10:0] idx;
    logic [15:0] bits;
  } rfr_evt_t;

  typedef enum logic [2:0] {
    WALK_IDLE = 3'b000,
    WALK_CLR  = 3'b001,
    WALK_FILE = 3'b011,
    WALK_WIN  = 3'b010
  } rfr_walk_t;
endpackage

// [rtl/rfr_map_walk.sv]
`timescale 1ns/1ns
module rfr_map_walk (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic              i_start,
  input  wire logic [15:0]       i_rd_data,
  output logic      [10:0]       o_rd_idx,
  output logic      [2047:0][1:0] o_role,
  output logic                   o_busy
);
  rfr_pkg::rfr_walk_t st_r;
  logic [12:0] idx_r;
  logic [15:0] files_r;
  logic [15:0] wins_r;
  logic [10:0] rlen_r;
  logic [1:0]  step_r;
  logic        phase_r;
  logic [2047:0][1:0] role_r;

  wire past_end  = idx_r >= rfr_pkg::IDX_END;
  wire [12:0] cmd_pos = idx_r + {2'h0, rlen_r} + rfr_pkg::WIN_CMD_SKIP;

  assign o_rd_idx = (st_r == rfr_pkg::WALK_CLR) ? rfr_pkg::IDX_FILE_CNT : idx_r[10:0];
  assign o_role   = role_r;
  assign o_busy   = st_r != rfr_pkg::WALK_IDLE;

  // one role per cycle keeps the map walk a single write port
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r    <= rfr_pkg::WALK_IDLE;
      idx_r   <= '0;
      files_r <= '0;
      wins_r  <= '0;
      rlen_r  <= '0;
      step_r  <= '0;
      phase_r <= 1'b0;
      role_r  <= '0;
    end else if (i_ce) begin
      if (i_start) begin
        st_r  <= rfr_pkg::WALK_CLR;
        idx_r <= '0;
      end else begin
        case (st_r)
          rfr_pkg::WALK_CLR: begin
            role_r[idx_r[10:0]] <= (idx_r[10:0] <= rfr_pkg::IDX_RATE_CODE) ?
                                   rfr_pkg::ROLE_CFG : rfr_pkg::ROLE_DATA;
            if (idx_r == rfr_pkg::IDX_END - 13'h0001) begin
              files_r <= i_rd_data;
              idx_r   <= rfr_pkg::IDX_FIRST_FILE;
              step_r  <= '0;
              st_r    <= rfr_pkg::WALK_FILE;
            end else begin
              idx_r <= idx_r + 13'h0001;
            end
          end
          rfr_pkg::WALK_FILE: begin
            if (files_r == 16'h0000 || past_end) begin
              st_r <= rfr_pkg::WALK_IDLE;
            end else begin
              role_r[idx_r[10:0]] <= rfr_pkg::ROLE_CFG; // [RQ3] [RQ4]
              if (step_r == rfr_pkg::HDR_STEP_RLEN) rlen_r <= i_rd_data[10:0];
              if (step_r == rfr_pkg::HDR_STEP_NWIN) wins_r <= i_rd_data;
              idx_r  <= idx_r + 13'h0001;
              step_r <= step_r + 2'h1;
              if (step_r == rfr_pkg::HDR_LAST_STEP) begin
                files_r <= files_r - 16'h0001;
                phase_r <= 1'b0;
                st_r    <= rfr_pkg::WALK_WIN;
              end
            end
          end
          rfr_pkg::WALK_WIN: begin
            if (wins_r == 16'h0000) begin
              step_r <= '0;
              st_r   <= rfr_pkg::WALK_FILE;
            end else if (past_end) begin
              st_r <= rfr_pkg::WALK_IDLE;
            end else if (!phase_r) begin
              role_r[idx_r[10:0]] <= rfr_pkg::ROLE_STAT; // [RQ8]
              idx_r   <= cmd_pos;
              phase_r <= 1'b1;
            end else begin
              role_r[idx_r[10:0]] <= rfr_pkg::ROLE_CMD; // [RQ8]
              idx_r   <= idx_r + 13'h0001;
              wins_r  <= wins_r - 16'h0001;
              phase_r <= 1'b0;
            end
          end
          default: st_r <= rfr_pkg::WALK_IDLE;
        endcase
      end
    end
  end
endmodule

// [rtl/rfr_regs.sv]
// Summary of operation
// RQ1: while the lock bit is set, configuration writes are ignored; clearing it restores them.
// RQ2: while write protect is set, store and delete commands are ignored.
// RQ3: file count at register 1, rate code at 2, file blocks follow, protection high.
// RQ4: each file block holds length, windows, top record, key length, then its windows.
// RQ5: a front-port write turns that register into an input for the rack side.
// RQ6: restore discards all contents; records return to their original slot numbers.
// RQ7: lock and write-protect bits read back through the front port.
// RQ8: each window is status, record number, record image, then command register.
// RQ9: host sets a command bit; device answers with done and result bits.
// RQ10: at most 2048 interface registers, numbered from one on the front port.
// RQ11: unused protection bits read zero and ignore writes.
`timescale 1ns/1ns
module rfr_regs (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire rfr_pkg::rfr_req_t i_rack,
  output logic      [15:0]       o_rack_rdata,
  input  wire rfr_pkg::rfr_req_t i_front,
  output logic      [15:0]       o_front_rdata,
  input  wire logic              i_restore,
  output rfr_pkg::rfr_evt_t      o_cmd,
  input  wire rfr_pkg::rfr_evt_t i_done,
  output logic                   o_lock,
  output logic                   o_wprot,
  output logic                   o_map_busy
);
  logic        rst_s1_r;
  logic        rst_s2_r;
  wire         rst_n = rst_s2_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  logic [2047:0][15:0] mem_r;
  logic [2047:0]       fown_r;
  logic [15:0]         prot_r;
  logic                start_r;
  rfr_pkg::rfr_evt_t   cmd_r;
  logic [15:0]         rack_rdata_r;
  logic [15:0]         front_rdata_r;
  logic [2047:0][1:0]  role;
  logic [10:0]         walk_idx;
  logic                walk_busy;

  wire lock  = prot_r[rfr_pkg::PROT_LOCK_BIT];
  wire wprot = prot_r[rfr_pkg::PROT_WP_BIT];

  // decode: register n sits at array index n-1, only 1..2048 exist
  wire        r_in_map = i_rack.addr >= rfr_pkg::ADDR_FIRST &&
                         i_rack.addr <= rfr_pkg::ADDR_LAST; // [RQ10]
  wire        f_in_map = i_front.addr >= rfr_pkg::ADDR_FIRST &&
                         i_front.addr <= rfr_pkg::ADDR_LAST; // [RQ10]
  wire [13:0] r_off    = i_rack.addr - rfr_pkg::ADDR_FIRST;
  wire [13:0] f_off    = i_front.addr - rfr_pkg::ADDR_FIRST;
  wire [10:0] r_idx    = r_off[10:0];
  wire [10:0] f_idx    = f_off[10:0];
  wire [1:0]  r_role   = role[r_idx];
  wire [1:0]  f_role   = role[f_idx];
  wire        r_prot   = i_rack.addr == rfr_pkg::ADDR_PROT;
  wire        f_prot   = i_front.addr == rfr_pkg::ADDR_PROT;

  wire r_cfg_blk = lock && r_role == rfr_pkg::ROLE_CFG; // [RQ1]
  wire f_cfg_blk = lock && f_role == rfr_pkg::ROLE_CFG; // [RQ1]

  // rack may not overwrite what the front port has taken over
  wire r_wen = i_rack.wr && r_in_map && !fown_r[r_idx] && !r_cfg_blk; // [RQ5]
  wire f_wen = i_front.wr && f_in_map && !f_cfg_blk;

  // store/delete bits are dropped under write protect, other commands pass
  wire [15:0] alter_blk = wprot ? rfr_pkg::CMD_ALTER_MASK : 16'h0000; // [RQ2]
  wire [15:0] r_val = (r_role == rfr_pkg::ROLE_CMD) ? (i_rack.wdata & ~alter_blk) :
                      i_rack.wdata;
  wire [15:0] f_val = (f_role == rfr_pkg::ROLE_CMD) ? (i_front.wdata & ~alter_blk) :
                      i_front.wdata;

  // front wins a same-cycle collision on the command register
  wire f_cmd    = f_wen && f_role == rfr_pkg::ROLE_CMD && f_val != 16'h0000; // [RQ9]
  wire r_cmd    = r_wen && r_role == rfr_pkg::ROLE_CMD && r_val != 16'h0000; // [RQ9]
  wire cmd_hit  = f_cmd || (r_cmd && !(f_wen && f_idx == r_idx));
  wire [10:0] cmd_idx  = f_cmd ? f_idx : r_idx;
  wire [15:0] cmd_bits = f_cmd ? f_val : r_val;

  wire done_ok  = i_done.valid && role[i_done.idx] == rfr_pkg::ROLE_STAT; // [RQ9]
  wire cfg_wr   = (f_wen && f_role == rfr_pkg::ROLE_CFG) ||
                  (r_wen && r_role == rfr_pkg::ROLE_CFG);

  wire [15:0] prot_nxt = f_prot && i_front.wr ? (i_front.wdata & rfr_pkg::PROT_MASK) :
                         (i_rack.wdata & rfr_pkg::PROT_MASK); // [RQ11]
  wire        prot_we  = (f_prot && i_front.wr) || (r_prot && i_rack.wr);

  wire [15:0] r_rd_nxt = r_prot ? prot_r : (r_in_map ? mem_r[r_idx] : 16'h0000);
  wire [15:0] f_rd_nxt = f_prot ? prot_r : (f_in_map ? mem_r[f_idx] : 16'h0000); // [RQ7]

  genvar gi;
  generate
    for (gi = 0; gi < rfr_pkg::REG_COUNT; gi++) begin : g_reg
      wire        f_hit = f_wen && f_idx == 11'(gi);
      wire        r_hit = r_wen && r_idx == 11'(gi);
      wire        d_hit = done_ok && i_done.idx == 11'(gi);
      wire [15:0] base  = f_hit ? f_val : (r_hit ? r_val : mem_r[gi]);
      // done bits or in after a host write, so a clear never hides an answer
      wire [15:0] nxt   = base | (d_hit ? i_done.bits : 16'h0000); // [RQ9]

      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_r[gi]  <= rfr_pkg::REG_RESET;
          fown_r[gi] <= 1'b0;
        end else if (i_ce) begin
          if (i_restore) begin
            mem_r[gi]  <= rfr_pkg::REG_RESET; // [RQ6]
            fown_r[gi] <= 1'b0;
          end else begin
            mem_r[gi]  <= nxt;
            fown_r[gi] <= fown_r[gi] | f_hit; // [RQ5]
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_r <= rfr_pkg::REG_RESET;
    end else if (i_ce) begin
      if (i_restore) prot_r <= rfr_pkg::REG_RESET; // [RQ6]
      else if (prot_we) prot_r <= prot_nxt; // [RQ1] [RQ2]
    end
  end

  // layout is rebuilt after reset, restore and any accepted config write
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_r <= 1'b1;
    end else if (i_ce) begin
      start_r <= i_restore || cfg_wr; // [RQ3] [RQ4]
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= '0;
    end else if (i_ce) begin
      cmd_r.valid <= cmd_hit; // [RQ9]
      cmd_r.idx   <= cmd_idx;
      cmd_r.bits  <= cmd_bits;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rack_rdata_r  <= '0;
      front_rdata_r <= '0;
    end else if (i_ce) begin
      if (i_rack.rd) rack_rdata_r <= r_rd_nxt;
      if (i_front.rd) front_rdata_r <= f_rd_nxt;
    end
  end

  rfr_map_walk u_walk (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_ce      (i_ce),
    .i_start   (start_r),
    .i_rd_data (mem_r[walk_idx]),
    .o_rd_idx  (walk_idx),
    .o_role    (role),
    .o_busy    (walk_busy)
  );

  assign o_rack_rdata  = rack_rdata_r;
  assign o_front_rdata = front_rdata_r;
  assign o_cmd         = cmd_r;
  assign o_lock        = lock;
  assign o_wprot       = wprot;
  assign o_map_busy    = walk_busy || start_r;
endmodule

// [tb/rfr_regs_chk.sv]
`timescale 1ns/1ns
module rfr_regs_chk (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_ce,
  input wire rfr_pkg::rfr_req_t i_rack,
  input wire logic [15:0]       o_rack_rdata,
  input wire rfr_pkg::rfr_req_t i_front,
  input wire logic [15:0]       o_front_rdata,
  input wire logic              i_restore,
  input wire rfr_pkg::rfr_evt_t o_cmd,
  input wire rfr_pkg::rfr_evt_t i_done,
  input wire logic              o_lock,
  input wire logic              o_wprot,
  input wire logic              o_map_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire quiet = !i_rack.wr && !i_front.wr;
  wire f_prot = i_front.wr && i_front.addr == rfr_pkg::ADDR_PROT;
  wire r_prot = i_rack.wr && i_rack.addr == rfr_pkg::ADDR_PROT;
  // front write then rack write to the same register
  sequence s_own;
    i_ce && i_front.wr && !o_lock && !o_wprot
      && i_front.addr inside {[rfr_pkg::ADDR_FIRST:rfr_pkg::ADDR_LAST]}
    ##1 i_ce && i_rack.wr && !i_front.wr && i_rack.addr == $past(i_front.addr);
  endsequence
  rack_prot_a: assert property (
    i_ce && quiet && i_rack.rd && i_rack.addr == rfr_pkg::ADDR_PROT
    |=> o_rack_rdata == {14'h0000, $past(o_wprot), $past(o_lock)})
    else $error("rack protection readback wrong");
  front_prot_a: assert property (
    i_ce && quiet && i_front.rd && i_front.addr == rfr_pkg::ADDR_PROT
    |=> o_front_rdata == {14'h0000, $past(o_wprot), $past(o_lock)})
    else $error("front protection readback wrong");
  unmapped_zero_a: assert property (
    i_ce && i_front.rd && (i_front.addr == 14'h0000 || (i_front.addr > rfr_pkg::ADDR_LAST
    && i_front.addr != rfr_pkg::ADDR_PROT)) |=> o_front_rdata == 16'h0000)
    else $error("unmapped read not zero");
  prot_write_a: assert property (
    i_ce && f_prot && !r_prot |=> o_lock == $past(i_front.wdata[0])
    && o_wprot == $past(i_front.wdata[1]))
    else $error("protection bits not taken");
  prot_hold_a: assert property (
    !i_restore && !f_prot && !r_prot |=> $stable(o_lock) && $stable(o_wprot))
    else $error("protection bits changed without write");
  front_own_a: assert property (
    s_own ##1 (i_ce && quiet && i_rack.rd && !i_done.valid && i_rack.addr == $past(i_rack.addr))
    |=> o_rack_rdata == $past(i_front.wdata, 3))
    else $error("rack overwrote front owned register");
  cmd_cause_a: assert property (
    o_cmd.valid |-> ($past(i_rack.wr) || $past(i_front.wr)) && o_cmd.bits != 16'h0000)
    else $error("command event without cause");
  cmd_wprot_a: assert property (
    o_cmd.valid && $past(o_wprot) |-> (o_cmd.bits & rfr_pkg::CMD_ALTER_MASK) == 16'h0000)
    else $error("store or delete passed write protect");
  restore_clr_a: assert property (
    i_ce && i_restore |=> !o_lock && !o_wprot && o_map_busy)
    else $error("restore did not clear");
endmodule
bind rfr_regs rfr_regs_chk i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .i_rack(i_rack), .o_rack_rdata(o_rack_rdata), .i_front(i_front),
  .o_front_rdata(o_front_rdata), .i_restore(i_restore), .o_cmd(o_cmd), .i_done(i_done),
  .o_lock(o_lock), .o_wprot(o_wprot), .o_map_busy(o_map_busy));

// [tb/rfr_engine_model.sv]
`timescale 1ns/1ns
module rfr_engine_model #(
  parameter int unsigned RLEN = 1,
  parameter int unsigned DLY  = 3
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire rfr_pkg::rfr_evt_t i_cmd,
  output rfr_pkg::rfr_evt_t      o_done
);
  logic [7:0]  cnt_r;
  logic [10:0] idx_r;
  logic [15:0] bits_r;
  // one job at a time; the bench spaces its commands
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 8'h00;
      idx_r <= 11'h000;
      bits_r <= 16'h0000;
    end else if (i_cmd.valid) begin
      cnt_r <= DLY[7:0];
      idx_r <= i_cmd.idx - 11'(RLEN + 2);
      bits_r <= i_cmd.bits | 16'h0800;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  // idle bus shows inverted data, never a stale match
  assign o_done.valid = cnt_r == 8'h01;
  assign o_done.idx = o_done.valid ? idx_r : ~idx_r;
  assign o_done.bits = o_done.valid ? bits_r : ~bits_r;
endmodule

// [tb/record_file_register_map_tb_top.sv]
`timescale 1ns/1ns
module record_file_register_map_tb_top;
  localparam logic [13:0] PROT = rfr_pkg::ADDR_PROT;
  logic              clk, rst_n, ce, restore, lock, wprot, busy, rr_d, fr_d;
  rfr_pkg::rfr_req_t rack, front;
  rfr_pkg::rfr_evt_t cmd, done;
  logic [15:0]       rack_rd, front_rd, v;
  logic [31:0]       seed;
  int                miscompares, compares;
  logic [15:0]       qr[$], qf[$];
  logic [26:0]       qc[$];
  logic [13:0]       ra[6] = '{14'h0001, 14'h0002, PROT, 14'h0000, 14'h0801, 14'h1fff};
  logic [15:0]       cv[6];
  rfr_regs i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_rack(rack),
    .o_rack_rdata(rack_rd), .i_front(front), .o_front_rdata(front_rd), .i_restore(restore),
    .o_cmd(cmd), .i_done(done), .o_lock(lock), .o_wprot(wprot), .o_map_busy(busy));
  rfr_engine_model #(.RLEN(1), .DLY(3)) i_eng (.i_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd),
    .o_done(done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task finish_test();
    // an expected result that never showed up is a failure too
    if (qr.size() != 0 || qf.size() != 0 || qc.size() != 0) miscompares++;
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk16(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task chkcmd(logic [26:0] e, logic [26:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL cmd expected %h seen %h", e, g);
    end
  endtask
  task automatic acc(bit f, bit w, logic [13:0] a, logic [15:0] d);
    rfr_pkg::rfr_req_t r;
    r = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    rack <= f ? '0 : r;
    front <= f ? r : '0;
  endtask
  task automatic rd(bit f, logic [13:0] a, logic [15:0] e);
    acc(f, 1'b0, a, 16'h0000);
    if (f) qf.push_back(e);
    else qr.push_back(e);
  endtask
  task idle(int n);
    repeat (n) begin
      @(posedge clk);
      rack <= '0;
      front <= '0;
      restore <= 1'b0;
    end
  endtask
  // rebuild may start a few cycles late, so settle first
  task wait_map();
    int i;
    idle(4);
    for (i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) begin
      miscompares++;
      finish_test();
    end
  endtask
  always @(posedge clk) begin
    if (rr_d) chk16("rack_rdata", qr.pop_front(), rack_rd);
    if (fr_d) chk16("front_rdata", qf.pop_front(), front_rd);
    if (cmd.valid === 1'b1) begin
      chkcmd(qc.size() ? qc.pop_front() : 27'h0, {cmd.idx, cmd.bits});
    end
    rr_d <= ce && rack.rd;
    fr_d <= ce && front.rd;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    restore = 1'b0;
    rack = '0;
    front = '0;
    rr_d = 1'b0;
    fr_d = 1'b0;
    seed = 32'h2336;
    miscompares = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_map();
    foreach (ra[i]) rd(i[0], ra[i], 16'h0000);
    v = rnd();
    acc(0, 1, rfr_pkg::ADDR_LAST, v);
    rd(0, rfr_pkg::ADDR_LAST, v);
    acc(1, 1, PROT, 16'hffff);
    rd(1, PROT, 16'h0003);
    acc(0, 1, 14'h0001, 16'h0005);
    rd(0, 14'h0001, 16'h0000);
    acc(1, 1, PROT, 16'h0000);
    cv = '{16'h0001, 16'h000d, 16'h0001, 16'h0001, rnd(), 16'h0000};
    for (int i = 0; i < 6; i++) begin
      acc(0, 1, 14'(i + 1), cv[i]);
      rd(0, 14'(i + 1), cv[i]);
    end
    wait_map();
    acc(0, 1, 14'h000a, 16'h0080);
    qc.push_back({11'h009, 16'h0080});
    idle(8);
    rd(0, 14'h0007, 16'h0880);
    acc(1, 1, PROT, 16'h0002);
    for (int i = 0; i < 6; i++) begin
      acc(0, 1, 14'h000a, 16'h0001 << i);
      idle(8);
    end
    acc(0, 1, 14'h000a, 16'h0090);
    qc.push_back({11'h009, 16'h0080});
    idle(8);
    acc(1, 1, PROT, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      acc(0, 1, 14'h000a, 16'h0001 << i);
      qc.push_back({11'h009, 16'h0001 << i});
      idle(8);
    end
    v = rnd();
    acc(1, 1, 14'h0014, v);
    acc(0, 1, 14'h0014, ~v);
    rd(0, 14'h0014, v);
    acc(1, 1, PROT, 16'h0003);
    @(posedge clk);
    restore <= 1'b1;
    rack <= '0;
    front <= '0;
    wait_map();
    rd(1, PROT, 16'h0000);
    rd(0, 14'h0014, 16'h0000);
    acc(0, 1, 14'h0014, v);
    rd(0, 14'h0014, v);
    idle(4);
    finish_test();
  end
endmodule
